// ---- verilog/csvc_pkg.sv ----
// constants shared by the comparator sync and reference control block
package csvc_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_CMP_CTRL1 = 12'h000;
    localparam logic [11:0] OFF_VREF_CTRL = 12'h004;
    localparam logic [11:0] OFF_TMR_CTRL  = 12'h008;
    localparam logic [11:0] OFF_TMR_COUNT = 12'h00C;
    localparam logic [11:0] OFF_STATUS    = 12'h010;
    // comparator_control_1 fields
    localparam int BIT_SYNC_EN  = 0;
    localparam int BIT_GATE_SRC = 1;
    localparam int BIT_HYST_EN  = 3;
    localparam int BIT_ALT_CLK  = 4;
    localparam logic [7:0] CTRL1_RESET = 8'h02;
    localparam logic [7:0] CTRL1_MASK  = 8'h1B;
    // voltage_reference_control fields
    localparam int LEVEL_LSB    = 0;
    localparam int LEVEL_W      = 4;
    localparam int BIT_FIXED_EN = 4;
    localparam int BIT_RANGE    = 5;
    localparam int BIT_LADDER   = 7;
    localparam logic [7:0] VREF_RESET = 8'h00;
    localparam logic [7:0] VREF_MASK  = 8'hBF;
    // timer control fields
    localparam int BIT_TMR_ON   = 0;
    localparam int BIT_GATE_EN  = 1;
    localparam int PRE_LSB      = 4;
    localparam int PRE_W        = 2;
    localparam logic [7:0] TMRC_RESET = 8'h00;
    localparam logic [7:0] TMRC_MASK  = 8'h33;
    // timer clock periods in core cycles before prescaling
    localparam logic [5:0] PER_FOSC  = 6'h01;
    localparam logic [5:0] PER_INSTR = 6'h04;
    localparam int TMR_COUNT_W = 16;
endpackage

// ---- verilog/csvc_tmr_if.sv ----
// timer clock events passed between the clock generator and the control core
interface csvc_tmr_if;
    logic                         altClkSel;
    logic [csvc_pkg::PRE_W-1:0]   prescale;
    logic                         riseEv;
    logic                         fallEv;
    modport gen (input altClkSel, input prescale, output riseEv, output fallEv);
    modport ctl (output altClkSel, output prescale, input riseEv, input fallEv);
endinterface

// ---- verilog/csvc_timer_clk.sv ----
// prescaled timer clock, expressed as rising and falling edge events
module csvc_timer_clk (
    input wire logic   core_clk,
    input wire logic   rstn,
    csvc_tmr_if.gen    tmr
);
    logic [5:0]                 phase;
    logic [5:0]                 period;
    logic [5:0]                 half;
    logic                       cfgPrevAlt;
    logic [csvc_pkg::PRE_W-1:0] cfgPrevPre;
    logic                       cfgChg;

    // source select then prescale
    assign period = (tmr.altClkSel ? csvc_pkg::PER_FOSC : csvc_pkg::PER_INSTR)
                    << tmr.prescale; // RULE5 RULE2
    assign half   = period >> 1;
    assign cfgChg = (cfgPrevAlt != tmr.altClkSel) || (cfgPrevPre != tmr.prescale);

    // phase restarts on any clock change so the edges never tear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            phase      <= 6'h00;
            cfgPrevAlt <= 1'b0;
            cfgPrevPre <= '0;
        end else begin
            cfgPrevAlt <= tmr.altClkSel;
            cfgPrevPre <= tmr.prescale;
            if (cfgChg || phase == 6'(period - 6'h01))
                phase <= 6'h00;
            else
                phase <= 6'(phase + 6'h01);
        end
    end

    // falling edge half a period after the rising one; coincide at period 1
    assign tmr.riseEv = (phase == 6'h00); // RULE3
    assign tmr.fallEv = (phase == half);  // RULE1

    instrRate_a: assert property (@(posedge core_clk) disable iff (!rstn || cfgChg)
        tmr.riseEv && !tmr.altClkSel && tmr.prescale == 2'd0
        |=> (!tmr.riseEv)[*3] ##1 tmr.riseEv) else $error("instr clock rate wrong"); // RULE5
    foscRate_a: assert property (@(posedge core_clk) disable iff (!rstn || cfgChg)
        tmr.altClkSel && tmr.prescale == 2'd0 |-> tmr.riseEv && tmr.fallEv)
        else $error("system clock rate wrong"); // RULE5
endmodule

// ---- verilog/csvc_cmp_sync.sv ----
// comparator output capture on the timer clock falling edge
module csvc_cmp_sync (
    input wire logic  core_clk,
    input wire logic  rstn,
    input wire logic  syncEn,
    input wire logic  cmpOut,
    csvc_tmr_if.ctl   tmr,
    output logic      cmpSel
);
    logic latched;

    // latch only on the prescaled falling edge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn)
            latched <= 1'b0;
        else if (tmr.fallEv)
            latched <= cmpOut; // RULE1 RULE2
    end

    // pass through when unsynchronized
    assign cmpSel = syncEn ? latched : cmpOut; // RULE4

    latchHold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !tmr.fallEv |=> $stable(latched)) else $error("latch moved off falling edge"); // RULE1
    latchTake_a: assert property (@(posedge core_clk) disable iff (!rstn)
        tmr.fallEv |=> latched == $past(cmpOut)) else $error("latch missed comparator"); // RULE1
endmodule

// ---- verilog/csvc_top.sv ----
// comparator sync, timer gate and voltage reference control with apb registers
// Overview of operation
// (RULE1) with sync on, comparator output latched at timer clock falling edge
// (RULE2) with a prescaler, the latch uses the prescaled timer clock
// (RULE3) timer counts on rising edges, opposite to the capture edge
// (RULE4) sync enable bit 0, reset 0; 1 latched, 0 passes through
// (RULE5) bit 4: 1 timer runs at system clock, 0 at system/4
// (RULE6) bit 3 drives hysteresis enable output; resets to 0
// (RULE7) bit 1 resets to 1: 1 external gate pin, 0 comparator
// (RULE8) unimplemented bits read zero and ignore writes
// (RULE9) ladder enable bit 7 powers ladder and routes it to comparator
// (RULE10) ladder enable 0 selects the fixed reference for comparator
// (RULE11) ladder enable 0 removes ladder power
// (RULE12) bit 5: 1 low ladder range, 0 high range; resets 0
// (RULE13) bits 3..0 pick one of 16 ladder taps; reset 0
// (RULE14) bit 4 turns fixed reference on or off; resets 0
// (RULE15) fixed reference forced on while fast internal oscillator runs
// (RULE16) both enables 0 clamp comparator reference to ground
// (RULE17) software waits for fixed reference settling before use
// (RULE18) software sets sync when comparator gates the timer
// (RULE19) the selected comparator output feeds the gate mux comparator input
module csvc_top (
    input wire logic         core_clk,
    input wire logic         rstn,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [11:0]  paddr,
    input wire logic [31:0]  pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input wire logic         cmpOut,
    input wire logic         extGatePin,
    input wire logic         hfInternalOscActive,
    output logic             cmpOutSync,
    output logic             timerGate,
    output logic             timerAltClkSel,
    output logic [15:0]      timerCount,
    output logic             cmpHysteresisEn,
    output logic             ladderPowerEn,
    output logic             ladderRefSel,
    output logic             ladderRangeSel,
    output logic [3:0]       ladderLevel,
    output logic             fixedRefPowerEn,
    output logic             refClampGnd
);
    logic [7:0]  comparatorControl1;
    logic [7:0]  voltageReferenceControl;
    logic [7:0]  timerControl;
    logic [csvc_pkg::TMR_COUNT_W-1:0] count;
    logic        cmpSel;
    logic        gateSrc;
    logic        countEn;
    logic        wrDone;
    logic        setup;
    logic        mapped;
    logic [31:0] next_prdata;

    csvc_tmr_if tmrIf ();

    // timer clock configuration straight from the registers
    assign tmrIf.altClkSel = comparatorControl1[csvc_pkg::BIT_ALT_CLK]; // RULE5
    assign tmrIf.prescale  = timerControl[csvc_pkg::PRE_LSB +: csvc_pkg::PRE_W]; // RULE2

    csvc_timer_clk uClk (
        .core_clk (core_clk),
        .rstn     (rstn),
        .tmr      (tmrIf.gen)
    );

    csvc_cmp_sync uSync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .syncEn   (comparatorControl1[csvc_pkg::BIT_SYNC_EN]), // RULE4
        .cmpOut   (cmpOut),
        .tmr      (tmrIf.ctl),
        .cmpSel   (cmpSel)
    );

    // apb: no wait state, pready rises in the first access cycle
    assign setup  = psel && !penable;
    assign wrDone = psel && penable && pready && pwrite;
    assign mapped = (paddr == csvc_pkg::OFF_CMP_CTRL1) || (paddr == csvc_pkg::OFF_VREF_CTRL)
                 || (paddr == csvc_pkg::OFF_TMR_CTRL) || (paddr == csvc_pkg::OFF_TMR_COUNT)
                 || (paddr == csvc_pkg::OFF_STATUS);

    // read mux; reserved bits are never stored so they read zero
    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            csvc_pkg::OFF_CMP_CTRL1: next_prdata[7:0] = comparatorControl1; // RULE8
            csvc_pkg::OFF_VREF_CTRL: next_prdata[7:0] = voltageReferenceControl; // RULE8
            csvc_pkg::OFF_TMR_CTRL:  next_prdata[7:0] = timerControl;
            csvc_pkg::OFF_TMR_COUNT: next_prdata[15:0] = count;
            csvc_pkg::OFF_STATUS:    next_prdata[2:0] = {timerGate, cmpSel, cmpOut};
            default:                 next_prdata = 32'h0000_0000;
        endcase
    end

    // bus answer registered at the setup cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite)
                prdata <= next_prdata;
            else if (setup)
                prdata <= 32'h0000_0000;
        end
    end

    // control registers; writes mask out unimplemented bits
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            comparatorControl1      <= csvc_pkg::CTRL1_RESET; // RULE4 RULE6 RULE7
            voltageReferenceControl <= csvc_pkg::VREF_RESET; // RULE12 RULE13 RULE14
            timerControl            <= csvc_pkg::TMRC_RESET;
        end else if (wrDone) begin
            if (paddr == csvc_pkg::OFF_CMP_CTRL1)
                comparatorControl1 <= pwdata[7:0] & csvc_pkg::CTRL1_MASK; // RULE8
            if (paddr == csvc_pkg::OFF_VREF_CTRL)
                voltageReferenceControl <= pwdata[7:0] & csvc_pkg::VREF_MASK; // RULE8
            if (paddr == csvc_pkg::OFF_TMR_CTRL)
                timerControl <= pwdata[7:0] & csvc_pkg::TMRC_MASK;
        end
    end

    // gate mux: the comparator side sees the same selected output as downstream
    assign gateSrc = comparatorControl1[csvc_pkg::BIT_GATE_SRC] ? extGatePin
                                                                : cmpSel; // RULE7 RULE19
    // gating read before the latch moves on a coinciding edge, so no race
    assign countEn = timerControl[csvc_pkg::BIT_TMR_ON]
                  && (!timerControl[csvc_pkg::BIT_GATE_EN] || gateSrc);

    // counter advances only on the rising timer clock event
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn)
            count <= '0;
        else if (tmrIf.riseEv && countEn)
            count <= count + csvc_pkg::TMR_COUNT_W'(1); // RULE3
    end

    // comparator side outputs
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cmpOutSync      <= 1'b0;
            timerGate       <= 1'b0;
            timerAltClkSel  <= 1'b0;
            timerCount      <= 16'h0000;
            cmpHysteresisEn <= 1'b0;
        end else begin
            cmpOutSync      <= cmpSel; // RULE1 RULE4
            timerGate       <= gateSrc; // RULE19
            timerAltClkSel  <= comparatorControl1[csvc_pkg::BIT_ALT_CLK]; // RULE5
            timerCount      <= count;
            cmpHysteresisEn <= comparatorControl1[csvc_pkg::BIT_HYST_EN]; // RULE6
        end
    end

    // reference side outputs; the hf oscillator keeps the fixed reference alive
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ladderPowerEn   <= 1'b0;
            ladderRefSel    <= 1'b0;
            ladderRangeSel  <= 1'b0;
            ladderLevel     <= 4'h0;
            fixedRefPowerEn <= 1'b0;
            refClampGnd     <= 1'b1;
        end else begin
            ladderPowerEn   <= voltageReferenceControl[csvc_pkg::BIT_LADDER]; // RULE9 RULE11
            ladderRefSel    <= voltageReferenceControl[csvc_pkg::BIT_LADDER]; // RULE9 RULE10
            ladderRangeSel  <= voltageReferenceControl[csvc_pkg::BIT_RANGE]; // RULE12
            ladderLevel     <= voltageReferenceControl[csvc_pkg::LEVEL_LSB +:
                                                       csvc_pkg::LEVEL_W]; // RULE13
            fixedRefPowerEn <= voltageReferenceControl[csvc_pkg::BIT_FIXED_EN]
                            || hfInternalOscActive; // RULE14 RULE15
            // clamp follows the bits only; settling is left to software
            refClampGnd     <= !voltageReferenceControl[csvc_pkg::BIT_LADDER]
                            && !voltageReferenceControl[csvc_pkg::BIT_FIXED_EN]; // RULE16
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    syncPath_a: assert property (comparatorControl1[0] && $stable(comparatorControl1[0])
        |=> cmpOutSync == $past(uSync.latched)) else $error("synced output wrong"); // RULE1
    asyncPath_a: assert property (!comparatorControl1[0]
        |=> cmpOutSync == $past(cmpOut)) else $error("async output wrong"); // RULE4
    countEdge_a: assert property (count != $past(count)
        |-> $past(tmrIf.riseEv)) else $error("count off rising edge"); // RULE3
    hystWrite_a: assert property (wrDone && paddr == csvc_pkg::OFF_CMP_CTRL1
        |=> ##1 cmpHysteresisEn == $past(pwdata[3], 2)) else $error("hysteresis wrong"); // RULE6
    gateMux_a: assert property (##1 timerGate == ($past(comparatorControl1[1])
        ? $past(extGatePin) : $past(cmpSel))) else $error("gate source wrong"); // RULE7
    reservedRead_a: assert property (pready && !pwrite && psel
        && (paddr == csvc_pkg::OFF_CMP_CTRL1 || paddr == csvc_pkg::OFF_VREF_CTRL)
        |-> prdata[31:8] == 24'h000000 && (prdata[7:0] & ~(paddr == csvc_pkg::OFF_CMP_CTRL1
        ? csvc_pkg::CTRL1_MASK : csvc_pkg::VREF_MASK)) == 8'h00)
        else $error("reserved bits not zero"); // RULE8
    ladderPower_a: assert property (##1 ladderPowerEn == $past(voltageReferenceControl[7])
        && ladderRefSel == ladderPowerEn) else $error("ladder power wrong"); // RULE9
    fixedSel_a: assert property (!voltageReferenceControl[7] |=> !ladderRefSel && !ladderPowerEn)
        else $error("fixed reference not selected"); // RULE10
    levelRange_a: assert property (wrDone && paddr == csvc_pkg::OFF_VREF_CTRL
        |=> ##1 ladderLevel == $past(pwdata[3:0], 2) && ladderRangeSel == $past(pwdata[5], 2))
        else $error("ladder tap wrong"); // RULE13
    hfForce_a: assert property (hfInternalOscActive |=> fixedRefPowerEn)
        else $error("fixed reference not forced"); // RULE15
    clampGnd_a: assert property (##1 refClampGnd == (!$past(voltageReferenceControl[7])
        && !$past(voltageReferenceControl[4]))) else $error("clamp wrong"); // RULE16

    // bus answer: one cycle of ready, only after a setup cycle
    readyPulse_a: assert property (
        pready |=> !pready)
        else $error("ready held past one cycle");
    readySetup_a: assert property (
        pready |-> $past(psel) && !$past(penable))
        else $error("ready without setup");
    errReady_a: assert property (
        pslverr |-> pready)
        else $error("error without ready");
    errMapped_a: assert property (
        pready |-> pslverr == !mapped)
        else $error("error flag wrong for address");
    badRead_a: assert property (
        pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    // a refused write must leave every register alone
    badWrite_a: assert property (
        wrDone && !mapped |=> $stable(comparatorControl1)
        && $stable(voltageReferenceControl) && $stable(timerControl))
        else $error("unmapped write landed");
    readCtrl_a: assert property ( // RULE8
        pready && !pwrite && paddr == csvc_pkg::OFF_CMP_CTRL1
        |-> prdata == {24'h00_0000, comparatorControl1})
        else $error("ctrl1 read wrong");

    // reserved bits can never be stored
    ctrlReserved_a: assert property ( // RULE8
        (comparatorControl1 & ~csvc_pkg::CTRL1_MASK) == 8'h00)
        else $error("ctrl1 reserved bit stored");
    vrefReserved_a: assert property ( // RULE8
        (voltageReferenceControl & ~csvc_pkg::VREF_MASK) == 8'h00)
        else $error("vref reserved bit stored");

    // count moves by one on an open rising event and holds otherwise
    countStep_a: assert property ( // RULE3
        tmrIf.riseEv && countEn |=> count == $past(count) + 16'h0001)
        else $error("count step wrong");
    countHold_a: assert property ( // RULE3
        !(tmrIf.riseEv && countEn) |=> $stable(count))
        else $error("count moved off rising event");
    countCopy_a: assert property (
        ##1 timerCount == $past(count))
        else $error("count output stale");
    // capture and count edges stay apart unless the period is one cycle
    edgeApart_a: assert property ( // RULE3
        tmrIf.riseEv && !(tmrIf.altClkSel && tmrIf.prescale == 2'h0) |-> !tmrIf.fallEv)
        else $error("capture and count edges coincide");
    // a clock change restarts the phase, so that attempt is dropped
    preHalf_a: assert property (disable iff (!rstn || uClk.cfgChg) // RULE2
        tmrIf.riseEv && !tmrIf.altClkSel && tmrIf.prescale == 2'h2 |-> ##8 tmrIf.fallEv)
        else $error("prescaled capture edge misplaced");

    // the gate sees the same comparator choice as the sync output
    gateLatch_a: assert property ( // RULE19
        comparatorControl1[1:0] == 2'h1 |-> gateSrc == uSync.latched)
        else $error("gate not fed by latched output");
    gatePass_a: assert property ( // RULE19
        comparatorControl1[1:0] == 2'h0 |-> gateSrc == cmpOut)
        else $error("gate not fed by comparator");
    gatePin_a: assert property ( // RULE7
        comparatorControl1[1] |-> gateSrc == extGatePin)
        else $error("gate not fed by pin");

    // each control output follows its register bits one cycle later; fixed power also follows the hf oscillator
    altCopy_a: assert property ( // RULE5
        ##1 timerAltClkSel == $past(comparatorControl1[4]))
        else $error("alt clock output wrong");
    hystCopy_a: assert property ( // RULE6
        ##1 cmpHysteresisEn == $past(comparatorControl1[3]))
        else $error("hysteresis output wrong");
    rangeCopy_a: assert property ( // RULE12
        ##1 ladderRangeSel == $past(voltageReferenceControl[5]))
        else $error("range output wrong");
    levelCopy_a: assert property ( // RULE13
        ##1 ladderLevel == $past(voltageReferenceControl[3:0]))
        else $error("level output wrong");
    fixedPower_a: assert property ( // RULE14 RULE15
        ##1 fixedRefPowerEn == ($past(voltageReferenceControl[4])
        || $past(hfInternalOscActive)))
        else $error("fixed reference power wrong");
    ladderOff_a: assert property ( // RULE11
        !voltageReferenceControl[7] |=> !ladderPowerEn)
        else $error("ladder left powered");
    clampOff_a: assert property ( // RULE16
        voltageReferenceControl[7] || voltageReferenceControl[4] |=> !refClampGnd)
        else $error("clamp left on");

    syncGate_c: cover property (comparatorControl1[1:0] == 2'b01 && tmrIf.riseEv && countEn);
    ladderOn_c: cover property (ladderPowerEn && ladderRangeSel && ladderLevel == 4'hF);
    clamp_c:    cover property (refClampGnd ##1 !refClampGnd);
    badAddr_c:  cover property (pslverr && pready);
    syncTake_c: cover property (comparatorControl1[0] && tmrIf.fallEv
        && cmpOut != uSync.latched);
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the comparator sync and reference control block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_C1 = csvc_pkg::OFF_CMP_CTRL1;
    localparam logic [11:0] A_VR = csvc_pkg::OFF_VREF_CTRL;
    localparam logic [11:0] A_TC = csvc_pkg::OFF_TMR_CTRL;
    logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic        cmpOut, extGatePin, hfInternalOscActive, cmpOutSync, timerGate;
    logic        timerAltClkSel, cmpHysteresisEn, ladderPowerEn, ladderRefSel;
    logic        ladderRangeSel, fixedRefPowerEn, refClampGnd;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] timerCount;
    logic [3:0]  ladderLevel;
    int          fail_count, n_tests, t0, t1;
    int          cyc = 0;

    csvc_top csvc_top_inst (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cmpOut, .extGatePin, .hfInternalOscActive, .cmpOutSync,
        .timerGate, .timerAltClkSel, .timerCount, .cmpHysteresisEn, .ladderPowerEn,
        .ladderRefSel, .ladderRangeSel, .ladderLevel, .fixedRefPowerEn, .refClampGnd);

    // 50 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        if (fail_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h got %h", nm, exp, got);
        end
    endtask

    // one apb transfer; an idle cycle follows so psel never toggles twice per step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // pready ends this wait, the hang guard only if pready never comes
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, exp, rd);
    endtask

    // outputs are registered, so give them a few edges to land
    task automatic settle;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic waitChg(output int t);
        logic v;
        v = cmpOutSync;
        while (cmpOutSync === v) begin
            @(posedge core_clk);
        end
        t = cyc;
    endtask

    // counts over a whole number of timer periods, so phase does not matter
    task automatic cntOver(input string nm, input int cycles, input logic [15:0] exp);
        logic [15:0] c0;
        logic [15:0] dd;
        c0 = timerCount;
        repeat (cycles) @(posedge core_clk);
        dd = timerCount - c0;
        chk(nm, {16'h0000, exp}, {16'h0000, dd});
    endtask

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        cmpOut = 1'b0;
        extGatePin = 1'b0;
        hfInternalOscActive = 1'b0;
        fail_count = 0;
        n_tests = 0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        chk("clamp after reset", 32'h0000_0001, {31'h0, refClampGnd});
        rdc("ctrl1 reset", A_C1, 32'h0000_0002);
        rdc("vref reset", A_VR, 32'h0000_0000);
        wr(A_C1, 8'hFF);
        rdc("ctrl1 reserved", A_C1, 32'h0000_001B);
        wr(A_VR, 8'hFF);
        rdc("vref reserved", A_VR, 32'h0000_00BF);
        settle();
        chk("hysteresis on", 32'h0000_0001, {31'h0, cmpHysteresisEn});
        chk("alt clock", 32'h0000_0001, {31'h0, timerAltClkSel});
        chk("ladder power", 32'h0000_0001, {31'h0, ladderPowerEn});
        chk("ladder routed", 32'h0000_0001, {31'h0, ladderRefSel});
        chk("low range", 32'h0000_0001, {31'h0, ladderRangeSel});
        chk("level max", 32'h0000_000F, {28'h0, ladderLevel});
        chk("fixed on", 32'h0000_0001, {31'h0, fixedRefPowerEn});
        chk("clamp off", 32'h0000_0000, {31'h0, refClampGnd});
        wr(A_C1, 8'h02);
        wr(A_VR, 8'h0A);
        settle();
        chk("hysteresis off", 32'h0000_0000, {31'h0, cmpHysteresisEn});
        chk("ladder unpowered", 32'h0000_0000, {31'h0, ladderPowerEn});
        chk("fixed routed", 32'h0000_0000, {31'h0, ladderRefSel});
        chk("high range", 32'h0000_0000, {31'h0, ladderRangeSel});
        chk("level mid", 32'h0000_000A, {28'h0, ladderLevel});
        chk("fixed off", 32'h0000_0000, {31'h0, fixedRefPowerEn});
        chk("clamp on", 32'h0000_0001, {31'h0, refClampGnd});
        hfInternalOscActive <= 1'b1;
        settle();
        chk("fixed forced", 32'h0000_0001, {31'h0, fixedRefPowerEn});
        hfInternalOscActive <= 1'b0;
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, err});
        chk("unmapped data", 32'h0000_0000, rd);
        wr(12'h020, 8'hFF);
        chk("unmapped write error", 32'h0000_0001, {31'h0, err});
        rdc("vref kept", A_VR, 32'h0000_000A);
        // gate mux: pin first, then comparator passed straight through
        extGatePin <= 1'b1;
        settle();
        chk("gate from pin", 32'h0000_0001, {31'h0, timerGate});
        wr(A_C1, 8'h00);
        extGatePin <= 1'b0;
        cmpOut <= 1'b1;
        settle();
        chk("gate from cmp", 32'h0000_0001, {31'h0, timerGate});
        chk("cmp passed", 32'h0000_0001, {31'h0, cmpOutSync});
        // synced capture only moves on prescaled falling events, period 16
        wr(A_TC, 8'h21);
        wr(A_C1, 8'h01);
        settle();
        cmpOut <= 1'b0;
        waitChg(t0);
        cmpOut <= 1'b1;
        waitChg(t1);
        chk("sync spacing", 32'h0000_0000, 32'((t1 - t0) % 16));
        chk("sync moved", 32'h0000_0001, {31'h0, t1 > t0});
        // counting rate by clock choice and prescale, then gating
        wr(A_TC, 8'h01);
        wr(A_C1, 8'h12);
        settle();
        cntOver("count fosc", 40, 16'h0028);
        wr(A_C1, 8'h02);
        settle();
        cntOver("count instr", 40, 16'h000A);
        wr(A_TC, 8'h21);
        settle();
        cntOver("count prescaled", 64, 16'h0004);
        wr(A_TC, 8'h23);
        settle();
        cntOver("count gated shut", 32, 16'h0000);
        extGatePin <= 1'b1;
        settle();
        cntOver("count gated open", 64, 16'h0004);
        print_verdict();
    end
endmodule
